// ---- hdl/gpt_pkg.sv ----
// shared constants, register map and types of the general purpose timer unit
package gpt_pkg;

  // clock and count-rate limits
  localparam int CLK_PERIOD_NS = 50;
  localparam int M1_MIN_COUNT_NS = 400;
  localparam int M2_MIN_COUNT_NS = 200;
  // least count period, rounded up to whole clock cycles
  localparam int M1_BASE_DIV = (M1_MIN_COUNT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int M2_BASE_DIV = (M2_MIN_COUNT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] M1_BASE_LAST = 4'(M1_BASE_DIV - 1);
  localparam logic [3:0] M2_BASE_LAST = 4'(M2_BASE_DIV - 1);

  localparam int TW = 16;
  localparam int NUM_TIMERS = 5;
  localparam int NUM_IRQ = 6;

  // timer array indices; index 5 is the capture register's interrupt source, not a timer
  localparam int IX_AUX_A = 0;
  localparam int IX_CORE = 1;
  localparam int IX_AUX_B = 2;
  localparam int IX_SAUX = 3;
  localparam int IX_SCORE = 4;
  localparam int IX_CAPTURE_RELOAD_REGISTER = 5;

  // register word indices; byte address is four times the index
  localparam logic [5:0] REG_CNT_BASE = 6'h00;
  localparam logic [5:0] REG_CAPTURE_RELOAD_REGISTER = 6'h05;
  localparam logic [5:0] REG_CON_BASE = 6'h06;
  localparam logic [5:0] REG_IC_BASE = 6'h0B;
  localparam logic [5:0] REG_LAST = 6'h10;

  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CON_RST = 16'h0000;
  localparam logic [7:0] IC_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GPT_MODE_TIMER,
    GPT_MODE_COUNTER,
    GPT_MODE_GATED,
    GPT_MODE_AUX
  } gpt_mode_t;

  // per-timer control word
  typedef struct packed {
    logic cap_en;      // second aux timer: capture into capture_reload_register
    logic opt;         // second aux: clear after capture; second core: reload on wrap
    logic aux_reload;  // aux mode: 1 reload, 0 capture
    logic out_en;      // toggle latch drives its pin
    logic ext_dir;     // core timer: direction pin flips the direction
    logic down;
    logic run;
    logic gate_hi;     // active gate level
    logic src_latch;   // count/reload trigger from the core toggle latch
    logic [1:0] edge_sel;  // bit0 rising, bit1 falling
    gpt_mode_t mode;
    logic [2:0] presc;
  } gpt_tcon_t;

  // per-source interrupt control
  typedef struct packed {
    logic flag;
    logic en;
    logic [1:0] pad;
    logic [3:0] prio;
  } gpt_ic_t;

  typedef struct packed {
    logic aux_a_in;
    logic core_in;
    logic aux_b_in;
    logic core_dir;
    logic cap_in;
  } gpt_pins_t;

endpackage : gpt_pkg

// ---- hdl/gpt_top.sv ----
// general purpose timer unit: two timer modules behind an AXI4-Lite slave
`timescale 1ns/1ps

module gpt_top (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire gpt_pkg::gpt_pins_t PINS,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic CORE_TOGGLE_OUT,
  output logic SECOND_CORE_TOGGLE_OUT,
  output logic SECOND_CORE_WRAP,
  output logic [5:0] IRQ_REQ
);
  import gpt_pkg::*;

  function automatic logic [16:0] step(input logic [15:0] v, input logic dn);
    if (dn) begin
      step = {v == 16'h0000, 16'(v - 16'h0001)};
    end else begin
      step = {v == 16'hFFFF, 16'(v + 16'h0001)};
    end
  endfunction : step
  function automatic logic ptick(input logic [7:0] pre, input logic [2:0] ps);
    logic [7:0] m;
    m = 8'((9'h001 << ps) - 9'h001);
    ptick = (pre & m) == m;
  endfunction : ptick
  function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] sel);
    edge_hit = (sel[0] & r) | (sel[1] & f);
  endfunction : edge_hit
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction : merge16
  // bus-side state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_wr;
  logic [5:0] wr_idx, rd_idx;
  // timer-side state
  logic [15:0] cnt_q [NUM_TIMERS];
  logic [15:0] cnt_d [NUM_TIMERS];
  gpt_tcon_t con_q [NUM_TIMERS];
  gpt_tcon_t con_d [NUM_TIMERS];
  gpt_ic_t ic_q [NUM_IRQ];
  gpt_ic_t ic_d [NUM_IRQ];
  logic [15:0] capr_q, capr_d;
  gpt_pins_t s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  logic [3:0] b1_q, b1_d, b2_q, b2_d;
  logic [7:0] pre1_q, pre1_d, pre2_q, pre2_d;
  logic tl3_q, tl3_d, tl6_q, tl6_d;
  logic core_toggle_output_pin_q, core_toggle_output_pin_d, second_core_toggle_output_pin_q, second_core_toggle_output_pin_d, wrap6_q, wrap6_d;
  logic [5:0] irq_q, irq_d;
  assign do_wr = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_idx = awaddr_q[7:2];
  assign rd_idx = S_AXI_ARADDR[7:2];
  // ---------------- AXI4-Lite slave ----------------
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (S_AXI_AWVALID & awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & wready_q) begin
      w_have_d = 1'b1;
      wdata_d = S_AXI_WDATA;
      wstrb_d = S_AXI_WSTRB;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_idx <= REG_LAST) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q & S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    // address and data are accepted again only after the response is taken
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d = ~w_have_d & ~bvalid_d;
    if (S_AXI_ARVALID & arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (rd_idx < REG_CAPTURE_RELOAD_REGISTER) begin
        rdata_d[15:0] = cnt_q[rd_idx[2:0]];
      end else if (rd_idx == REG_CAPTURE_RELOAD_REGISTER) begin
        rdata_d[15:0] = capr_q;
      end else if (rd_idx < REG_IC_BASE) begin
        rdata_d[15:0] = con_q[3'(rd_idx - REG_CON_BASE)];
      end else if (rd_idx <= REG_LAST) begin
        rdata_d[7:0] = ic_q[3'(rd_idx - REG_IC_BASE)];
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end else if (rvalid_q & S_AXI_RREADY) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (CE) begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      // ready rises the first enabled cycle after reset
      arready_q <= arready_d | (~arready_q & ~rvalid_q);
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  // ---------------- timers ----------------
  logic tb1, tb2, lrise, lfall, l6rise, l6fall, dir3, inc;
  logic [1:0] arise, afall, reload3;
  logic [16:0] w;
  logic [5:0] ev;
  gpt_pins_t rise, fall;
  gpt_tcon_t c;
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      cnt_d[i] = cnt_q[i];
      con_d[i] = con_q[i];
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      ic_d[i] = ic_q[i];
    end
    capr_d = capr_q;
    tl3_d = tl3_q;
    tl6_d = tl6_q;
    ev = 6'h00;
    reload3 = 2'b00;
    w = 17'h00000;
    inc = 1'b0;
    c = con_q[IX_CORE];
    // two-stage synchroniser, third stage only for edge detection
    s1_d = PINS;
    s2_d = s1_q;
    s3_d = s2_q;
    rise = s2_q & ~s3_q;
    fall = ~s2_q & s3_q;
    arise = {rise.aux_b_in, rise.aux_a_in};
    afall = {fall.aux_b_in, fall.aux_a_in};
    // base ticks bound the fastest count rate of each module in timer and gated mode; counter mode steps on its input edges
    tb1 = (b1_q == M1_BASE_LAST);
    tb2 = (b2_q == M2_BASE_LAST);
    b1_d = tb1 ? 4'h0 : 4'(b1_q + 4'h1);
    b2_d = tb2 ? 4'h0 : 4'(b2_q + 4'h1);
    pre1_d = tb1 ? 8'(pre1_q + 8'h01) : pre1_q;
    pre2_d = tb2 ? 8'(pre2_q + 8'h01) : pre2_q;
    // core timer
    dir3 = c.down ^ (c.ext_dir & s2_q.core_dir);
    unique case (c.mode)
      GPT_MODE_COUNTER: inc = edge_hit(rise.core_in, fall.core_in, c.edge_sel);
      GPT_MODE_GATED: inc = tb1 & ptick(pre1_q, c.presc) & (s2_q.core_in == c.gate_hi);
      default: inc = tb1 & ptick(pre1_q, c.presc);
    endcase
    inc = inc & c.run;
    w = step(cnt_q[IX_CORE], dir3);
    if (inc) begin
      cnt_d[IX_CORE] = w[15:0];
    end
    lrise = inc & w[16] & ~tl3_q;
    lfall = inc & w[16] & tl3_q;
    if (inc & w[16]) begin
      tl3_d = ~tl3_q;
      ev[IX_CORE] = 1'b1;
    end
    // auxiliary timers of module one
    for (int j = 0; j < 2; j++) begin
      c = con_q[2 * j];
      if (c.mode == GPT_MODE_AUX) begin
        // stopped while acting as capture or reload register
        if (!c.aux_reload) begin
          if (edge_hit(arise[j], afall[j], c.edge_sel)) begin
            cnt_d[2 * j] = cnt_q[IX_CORE];
            ev[2 * j] = 1'b1;
          end
        end else if (c.src_latch ? edge_hit(lrise, lfall, c.edge_sel)
                                 : edge_hit(arise[j], afall[j], c.edge_sel)) begin
          reload3[j] = 1'b1;
        end
      end else begin
        unique case (c.mode)
          GPT_MODE_COUNTER: begin
            inc = c.src_latch ? edge_hit(lrise, lfall, c.edge_sel)
                              : edge_hit(arise[j], afall[j], c.edge_sel);
          end
          GPT_MODE_GATED: begin
            inc = tb1 & ptick(pre1_q, c.presc) &
                  ((j == 0 ? s2_q.aux_a_in : s2_q.aux_b_in) == c.gate_hi);
          end
          default: inc = tb1 & ptick(pre1_q, c.presc);
        endcase
        w = step(cnt_q[2 * j], c.down);
        if (inc & c.run) begin
          cnt_d[2 * j] = w[15:0];
          ev[2 * j] = w[16];
        end
      end
    end
    // each aux timer reloads on the edges its own edge_sel picks; rising on one, falling on the other gives PWM with no software
    if (reload3[0]) begin
      cnt_d[IX_CORE] = cnt_q[IX_AUX_A];
    end else if (reload3[1]) begin
      cnt_d[IX_CORE] = cnt_q[IX_AUX_B];
    end
    // second core timer
    c = con_q[IX_SCORE];
    w = step(cnt_q[IX_SCORE], c.down);
    inc = c.run & tb2 & ptick(pre2_q, c.presc);
    if (inc) begin
      cnt_d[IX_SCORE] = (w[16] & c.opt) ? capr_q : w[15:0];
    end
    wrap6_d = inc & w[16];
    l6rise = wrap6_d & ~tl6_q;
    l6fall = wrap6_d & tl6_q;
    if (wrap6_d) begin
      tl6_d = ~tl6_q;
      ev[IX_SCORE] = 1'b1;
    end
    // second aux timer: prescaled or chained to the second core latch
    c = con_q[IX_SAUX];
    w = step(cnt_q[IX_SAUX], c.down);
    inc = c.run & ((c.mode == GPT_MODE_COUNTER) ? (l6rise | l6fall)
                                                : (tb2 & ptick(pre2_q, c.presc)));
    if (inc) begin
      cnt_d[IX_SAUX] = w[15:0];
      ev[IX_SAUX] = w[16];
    end
    if (c.cap_en & edge_hit(rise.cap_in, fall.cap_in, c.edge_sel)) begin
      capr_d = cnt_q[IX_SAUX];
      ev[IX_CAPTURE_RELOAD_REGISTER] = 1'b1;
      if (c.opt) begin
        cnt_d[IX_SAUX] = CNT_RST;
      end
    end

    // a software write to a count wins over the hardware update of the same cycle
    if (do_wr) begin
      if (wr_idx < REG_CAPTURE_RELOAD_REGISTER) begin
        cnt_d[wr_idx[2:0]] = merge16(cnt_q[wr_idx[2:0]], wdata_q, wstrb_q);
      end else if (wr_idx == REG_CAPTURE_RELOAD_REGISTER) begin
        capr_d = merge16(capr_q, wdata_q, wstrb_q);
      end else if (wr_idx < REG_IC_BASE) begin
        con_d[3'(wr_idx - REG_CON_BASE)] =
          merge16(con_q[3'(wr_idx - REG_CON_BASE)], wdata_q, wstrb_q);
      end else if (wr_idx <= REG_LAST && wstrb_q[0]) begin
        ic_d[3'(wr_idx - REG_IC_BASE)] = wdata_q[7:0];
        ic_d[3'(wr_idx - REG_IC_BASE)].pad = 2'b00;
      end
    end
    // hardware set wins over a software clear
    for (int i = 0; i < NUM_IRQ; i++) begin
      ic_d[i].flag = ic_d[i].flag | ev[i];
      irq_d[i] = ic_d[i].flag & ic_d[i].en;
    end
    core_toggle_output_pin_d = tl3_d & con_d[IX_CORE].out_en;
    second_core_toggle_output_pin_d = tl6_d & con_d[IX_SCORE].out_en;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        cnt_q[i] <= CNT_RST;
        con_q[i] <= CON_RST;
      end
      for (int i = 0; i < NUM_IRQ; i++) begin
        ic_q[i] <= IC_RST;
      end
      capr_q <= CNT_RST;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      b1_q <= 4'h0;
      b2_q <= 4'h0;
      pre1_q <= 8'h00;
      pre2_q <= 8'h00;
      tl3_q <= 1'b0;
      tl6_q <= 1'b0;
      core_toggle_output_pin_q <= 1'b0;
      second_core_toggle_output_pin_q <= 1'b0;
      wrap6_q <= 1'b0;
      irq_q <= 6'h00;
    end else if (CE) begin
      cnt_q <= cnt_d;
      con_q <= con_d;
      ic_q <= ic_d;
      capr_q <= capr_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
      tl3_q <= tl3_d;
      tl6_q <= tl6_d;
      core_toggle_output_pin_q <= core_toggle_output_pin_d;
      second_core_toggle_output_pin_q <= second_core_toggle_output_pin_d;
      wrap6_q <= wrap6_d;
      irq_q <= irq_d;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;
  assign CORE_TOGGLE_OUT = core_toggle_output_pin_q;
  assign SECOND_CORE_TOGGLE_OUT = second_core_toggle_output_pin_q;
  assign SECOND_CORE_WRAP = wrap6_q;
  assign IRQ_REQ = irq_q;

endmodule : gpt_top

// ---- dv/gpt_checker.sv ----
// port-level assertions for the timer unit, bound to its top module
`timescale 1ns/1ps
module gpt_checker
  import gpt_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CORE_TOGGLE_OUT,
  input wire logic SECOND_CORE_WRAP,
  input wire logic [5:0] IRQ_REQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_wr_both;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence

  // both halves are registered first, so the answer comes on the second edge
  a_write_answer: assert property (s_wr_both |=> ##1 S_AXI_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read response missing");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  a_read_width: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("read data wider than 16 bits");
  a_unmapped_read: assert property (s_rd_take ##0 (S_AXI_ARADDR[7:2] > REG_LAST) |=>
    S_AXI_RRESP == RESP_SLVERR) else $error("unmapped read not refused");
  a_wrap_spacing: assert property (SECOND_CORE_WRAP |=> !SECOND_CORE_WRAP [*3])
    else $error("second core wraps too fast");
  a_core_rate: assert property ($changed(CORE_TOGGLE_OUT) |=> $stable(CORE_TOGGLE_OUT) [*7])
    else $error("core toggle changes too fast");
  a_reset_quiet: assert property ($rose(RSTN) |-> IRQ_REQ == 6'h00 && !CORE_TOGGLE_OUT)
    else $error("outputs not cleared by reset");
endmodule : gpt_checker

bind gpt_top gpt_checker i_chk (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .CORE_TOGGLE_OUT(CORE_TOGGLE_OUT),
  .SECOND_CORE_WRAP(SECOND_CORE_WRAP), .IRQ_REQ(IRQ_REQ)
);

// ---- dv/gpt_pin_model.sv ----
// external pin model: gate, count, direction and capture inputs
`timescale 1ns/1ps
module gpt_pin_model (
  input wire logic core_clk,
  output gpt_pkg::gpt_pins_t pins
);
  import gpt_pkg::*;
  initial pins = '0;
  // pulses stay wide so the synchroniser sees every level
  task automatic pulse(input int ix, input int n);
    repeat (n) begin
      repeat (10) @(posedge core_clk);
      pins[ix] <= 1'b1;
      repeat (10) @(posedge core_clk);
      pins[ix] <= 1'b0;
    end
  endtask : pulse
  task automatic level(input int ix, input logic v);
    @(posedge core_clk);
    pins[ix] <= v;
  endtask : level
endmodule : gpt_pin_model

// ---- dv/gpt_top_tb_top.sv ----
// self-checking bench for the timer unit over its register bus
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module gpt_top_tb_top;
  import gpt_pkg::*;
  logic core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tog, stog, swrap;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] irq;
  logic [15:0] a, b;
  gpt_pins_t pins;
  int bad_count, num_checks;

  gpt_pin_model i_pins (.core_clk(core_clk), .pins(pins));
  gpt_top i_dut (
    .CORE_CLK(core_clk), .RSTN(rstn), .CE(1'b1), .PINS(pins),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CORE_TOGGLE_OUT(tog),
    .SECOND_CORE_TOGGLE_OUT(stog), .SECOND_CORE_WRAP(swrap), .IRQ_REQ(irq)
  );

  task report_and_stop;
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task time_out;
    bad_count++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask : time_out
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  function automatic logic [7:0] adr(input logic [5:0] base, input int ix);
    return {base + 6'(ix), 2'b00};
  endfunction : adr

  task automatic axi_wr(input logic [7:0] ad, input logic [15:0] d, output logic [1:0] r);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    @(posedge core_clk);
    awaddr <= ad;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (++n > 50) time_out();
    end
    do begin
      @(posedge core_clk);
      if (++n > 100) time_out();
    end while (!bvalid);
    // late ready: the slave must hold its response for a cycle
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (++n > 150) time_out();
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] ad, output logic [15:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= ad;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (++n > 50) time_out();
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      if (++n > 100) time_out();
    end while (!rvalid);
    // late ready: the slave must hold its read data for a cycle
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (++n > 150) time_out();
    end while (!rvalid);
    d = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(ad, d, r);
    `CHK(r, RESP_OKAY)
  endtask : wr
  task automatic rd_chk(input logic [7:0] ad, input logic [15:0] e);
    logic [15:0] d;
    logic [1:0] r;
    axi_rd(ad, d, r);
    `CHK(r, RESP_OKAY)
    `CHK(d, e)
  endtask : rd_chk

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    bad_count = 0;
    num_checks = 0;
    cyc(12);
    rstn <= 1'b1;
    cyc(2);
    for (int i = 0; i < 6; i++) rd_chk(adr(REG_CNT_BASE, i), CNT_RST);
    axi_rd(8'h44, a, rs);
    `CHK(rs, RESP_SLVERR)
    axi_wr(8'h44, 16'hFFFF, rs);
    `CHK(rs, RESP_SLVERR)
    // core wraps from the top, latch flips and raises its request
    wr(adr(REG_CNT_BASE, IX_CORE), 16'hFFFF);
    wr(adr(REG_IC_BASE, IX_CORE), 16'h0040);
    wr(adr(REG_CON_BASE, IX_CORE), 16'h1200);
    cyc(20);
    `CHK(tog, 1'b1)
    `CHK(irq[IX_CORE], 1'b1)
    rd_chk(adr(REG_IC_BASE, IX_CORE), 16'h00C0);
    // one step per 8 clocks; the bus adds a step of slack either way
    wr(adr(REG_CNT_BASE, IX_CORE), 16'h0000);
    cyc(80);
    axi_rd(adr(REG_CNT_BASE, IX_CORE), a, rs);
    `CHK(a >= 16'd9 && a <= 16'd11, 1'b1)
    i_pins.level(1, 1'b1);
    wr(adr(REG_CON_BASE, IX_CORE), 16'h0A00);
    wr(adr(REG_CNT_BASE, IX_CORE), 16'h0100);
    cyc(80);
    axi_rd(adr(REG_CNT_BASE, IX_CORE), a, rs);
    `CHK(a >= 16'h00F5 && a <= 16'h00F7, 1'b1)
    wr(adr(REG_CON_BASE, IX_CORE), 16'h0000);
    wr(adr(REG_CNT_BASE, IX_CORE), 16'hABCD);
    wr(adr(REG_CON_BASE, IX_AUX_B), 16'h0038);
    i_pins.pulse(2, 1);
    rd_chk(adr(REG_CNT_BASE, IX_AUX_B), 16'hABCD);
    wr(adr(REG_CON_BASE, IX_AUX_A), 16'h0228);
    i_pins.pulse(4, 5);
    rd_chk(adr(REG_CNT_BASE, IX_AUX_A), 16'h0005);
    wr(adr(REG_CON_BASE, IX_AUX_A), 16'h2038);
    i_pins.pulse(4, 1);
    rd_chk(adr(REG_CNT_BASE, IX_CORE), 16'h0005);
    // aux a counts both core latch transitions; one core wrap adds one
    wr(adr(REG_CON_BASE, IX_AUX_A), 16'h02E8);
    wr(adr(REG_CNT_BASE, IX_CORE), 16'hFFFF);
    wr(adr(REG_CON_BASE, IX_CORE), 16'h0200);
    cyc(20);
    rd_chk(adr(REG_CNT_BASE, IX_AUX_A), 16'h0006);
    // gated: counts only while the gate pin is high
    wr(adr(REG_CNT_BASE, IX_AUX_B), 16'h0000);
    wr(adr(REG_CON_BASE, IX_AUX_B), 16'h0310);
    cyc(40);
    rd_chk(adr(REG_CNT_BASE, IX_AUX_B), 16'h0000);
    i_pins.level(2, 1'b1);
    cyc(80);
    i_pins.level(2, 1'b0);
    cyc(10);
    axi_rd(adr(REG_CNT_BASE, IX_AUX_B), a, rs);
    `CHK(a >= 16'd9 && a <= 16'd11, 1'b1)
    cyc(40);
    axi_rd(adr(REG_CNT_BASE, IX_AUX_B), b, rs);
    `CHK(b, a)
    wr(adr(REG_CNT_BASE, IX_SAUX), 16'h1234);
    wr(adr(REG_CON_BASE, IX_SAUX), 16'h8020);
    i_pins.pulse(0, 1);
    rd_chk(adr(REG_CNT_BASE, IX_CAPTURE_RELOAD_REGISTER), 16'h1234);
    wr(adr(REG_CON_BASE, IX_SAUX), 16'hC020);
    wr(adr(REG_CNT_BASE, IX_SAUX), 16'h5678);
    i_pins.pulse(0, 1);
    rd_chk(adr(REG_CNT_BASE, IX_CAPTURE_RELOAD_REGISTER), 16'h5678);
    rd_chk(adr(REG_CNT_BASE, IX_SAUX), 16'h0000);
    rd_chk(adr(REG_IC_BASE, IX_CAPTURE_RELOAD_REGISTER), 16'h0080);
    wr(adr(REG_CON_BASE, IX_SAUX), 16'h0208);
    // second core wraps within one base tick of module two
    wr(adr(REG_CNT_BASE, IX_SCORE), 16'hFFFF);
    wr(adr(REG_CON_BASE, IX_SCORE), 16'h1200);
    for (int n = 0; n < 20 && swrap !== 1'b1; n++) @(posedge core_clk);
    `CHK(swrap, 1'b1)
    cyc(2);
    `CHK(stog, 1'b1)
    rd_chk(adr(REG_CNT_BASE, IX_SAUX), 16'h0001);
    report_and_stop();
  end
endmodule : gpt_top_tb_top
